//--- core/cmgf_consts.svh
// Reset values and fixed counts for the gated clock fanout
`ifndef CMGF_CONSTS_SVH
`define CMGF_CONSTS_SVH
`define CMGF_NUM_OUT 4
`define CMGF_SYNC_RST 6'h00
`define CMGF_SEL_DIFF 1'h1
`endif

//--- core/cmgf_pkg.sv
// Types shared by the gated clock fanout
package cmgf_pkg;
    // Sampled input clocks and controls, after synchronisation
    typedef struct packed {
        logic diff_in_pos;
        logic diff_in_neg;
        logic single_ended_in;
        logic src_sel;
        logic clk_en;
        logic out_en;
    } cmgf_in_t;
    // Enable gate states, one-hot
    typedef enum logic [1:0] {
        CMGF_GATE_OFF = 2'b01,
        CMGF_GATE_ON = 2'b10
    } cmgf_gate_t;
endpackage

//--- core/cmgf_fanout.sv
// Glitch-free two-source clock fanout with four gated, tri-stateable outputs
// Operation
// - Source select high routes the differential pair, low the single-ended clock.
// - Output drive enable low releases all four outputs regardless of other inputs.
// - With drive on and clock enable low, outputs stay static low.
// - Clock enable is synchronised so enable changes never cause runt pulses.
// - Enable change takes effect only after a selected rising then falling edge.
// - One selected clock drives four identical outputs, gated and released together.
`timescale 1ns/10ps
`include "cmgf_consts.svh"
module cmgf_fanout #(
    parameter int NUM_OUT = `CMGF_NUM_OUT
) (
    // System clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    // Input clocks from the upstream source
    input wire logic I_DIFF_IN_POS,
    input wire logic I_DIFF_IN_NEG,
    input wire logic I_SINGLE_ENDED_IN,
    // Control pins
    input wire logic I_SRC_SEL,
    input wire logic I_CLK_EN,
    input wire logic I_OUT_EN,
    // Fanout outputs; enable is low while driving
    output logic [NUM_OUT-1:0] O_FANOUT_OUTPUTS,
    output logic [NUM_OUT-1:0] O_FANOUT_OUTPUTS_OE_N
);
    // Elaboration checks: an empty fanout has nothing to drive, and the pin
    // vector below is cast straight onto the input struct
    if (NUM_OUT < 1) begin : g_bad_num_out
        $error("NUM_OUT must be at least one");
    end
    if ($bits(cmgf_pkg::cmgf_in_t) != 6) begin : g_bad_pin_vector
        $error("Input struct must hold six pins");
    end

    // Limitation: every input clock is sampled by the system clock, so each phase
    // of a selected clock must last several system cycles; a faster input aliases
    // and its gated copy loses or merges pulses

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Every pin is asynchronous to the system clock, so each gets two flops
    // Reset clears both stages, so no pin looks high until two real samples arrive
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    cmgf_pkg::cmgf_in_t pin_s;
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            meta_q <= `CMGF_SYNC_RST;
            sync_q <= `CMGF_SYNC_RST;
        end else begin
            meta_q <= {I_DIFF_IN_POS, I_DIFF_IN_NEG, I_SINGLE_ENDED_IN, I_SRC_SEL, I_CLK_EN, I_OUT_EN};
            sync_q <= meta_q;
        end
    end
    assign pin_s = cmgf_pkg::cmgf_in_t'(sync_q);

    // ****************************************
    // Source selection
    // ****************************************
    // Differential receiver: positive above negative means high; a pair that
    // sits equal reads as low, so an idle differential source rests low
    wire diff_clk = pin_s.diff_in_pos & ~pin_s.diff_in_neg;
    // The select is a plain level: switching it mid-phase may cut one pulse, so
    // hold the clock enable low while the source changes
    wire sel_clk = (pin_s.src_sel == `CMGF_SEL_DIFF) ? diff_clk : pin_s.single_ended_in;

    // Edge tracking of the selected clock
    // A rise or fall marks the first system cycle that sees the new level
    logic sel_clk_q;
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            sel_clk_q <= 1'b0;
        end else begin
            sel_clk_q <= sel_clk;
        end
    end
    wire rise = sel_clk & ~sel_clk_q;
    wire fall = ~sel_clk & sel_clk_q;

    // ****************************************
    // Enable synchroniser to the selected clock
    // ****************************************
    // First stage captures the enable on a rising edge of the selected clock
    logic en_rise_q;
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            en_rise_q <= 1'b0;
        end else if (rise) begin
            en_rise_q <= pin_s.clk_en;
        end
    end

    // Second stage: latch open only while the clock is low, so the gate
    // moves on the falling edge and never cuts a high phase short
    // The flop stands in for a level latch so the whole block stays on one clock
    cmgf_pkg::cmgf_gate_t gate_q;
    cmgf_pkg::cmgf_gate_t gate_d;
    always_comb begin
        gate_d = gate_q;
        case (gate_q)
            cmgf_pkg::CMGF_GATE_OFF: begin
                if (~sel_clk & en_rise_q) gate_d = cmgf_pkg::CMGF_GATE_ON;
            end
            cmgf_pkg::CMGF_GATE_ON: begin
                if (~sel_clk & ~en_rise_q) gate_d = cmgf_pkg::CMGF_GATE_OFF;
            end
            default: gate_d = cmgf_pkg::CMGF_GATE_OFF;
        endcase
    end
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            gate_q <= cmgf_pkg::CMGF_GATE_OFF;
        end else begin
            gate_q <= gate_d;
        end
    end
    // Decoded once for the AND gate and the checks
    wire gate_on = (gate_q == cmgf_pkg::CMGF_GATE_ON);

    // ****************************************
    // Output stage
    // ****************************************
    // Clock ANDed with the latched enable; outputs registered and replicated
    // Each copy has its own flop fed from the same wire, so all copies change in
    // the same cycle; the cost is one more cycle of latency behind the pins
    wire gated_clk = sel_clk & gate_on;
    logic [NUM_OUT-1:0] out_q;
    logic [NUM_OUT-1:0] oe_n_q;
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            out_q <= '0;
            oe_n_q <= '1;
        end else begin
            out_q <= {NUM_OUT{gated_clk}};
            oe_n_q <= {NUM_OUT{~pin_s.out_en}};
        end
    end
    assign O_FANOUT_OUTPUTS = out_q;
    assign O_FANOUT_OUTPUTS_OE_N = oe_n_q;

    // ****************************************
    // Pulse width tracker
    // ****************************************
    // Lengths of the current high run of the selected clock and of its gated
    // copy; both saturate so a stopped clock cannot wrap them
    // Only the checks read these counters
    logic [7:0] src_run_q;
    logic [7:0] gated_run_q;
    wire [7:0] src_run_d = sel_clk ? ((src_run_q == 8'hff) ? src_run_q : src_run_q + 8'h01) : 8'h00;
    wire [7:0] gated_run_d = gated_clk ? ((gated_run_q == 8'hff) ? gated_run_q : gated_run_q + 8'h01) : 8'h00;
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            src_run_q <= 8'h00;
            gated_run_q <= 8'h00;
        end else begin
            src_run_q <= src_run_d;
            gated_run_q <= gated_run_d;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Drive and gate checks against the synchronised pins
    a_release_when_off: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        !pin_s.out_en |=> (O_FANOUT_OUTPUTS_OE_N == '1)) else $error("Outputs driven while disabled");
    a_drive_when_on: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        pin_s.out_en |=> (O_FANOUT_OUTPUTS_OE_N == '0)) else $error("Outputs released while enabled");
    a_low_when_gated: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        !gate_on |=> (O_FANOUT_OUTPUTS == '0)) else $error("Output high while gated off");
    a_follow_when_on: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        gate_on |=> (O_FANOUT_OUTPUTS[0] == $past(sel_clk))) else $error("Output not following clock");
    a_outputs_equal: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (O_FANOUT_OUTPUTS == {NUM_OUT{O_FANOUT_OUTPUTS[0]}})) else $error("Outputs differ");
    a_gate_moves_low: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        $changed(gate_q) |-> !$past(sel_clk)) else $error("Gate moved while clock high");
    a_no_runt_cut: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (gate_on && sel_clk) |=> gate_on) else $error("High pulse cut short");
    a_enable_needs_rise: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        $rose(gate_on) |-> $past(en_rise_q)) else $error("Enabled without rising edge sample");

    // ****************************************
    // Gate timing checks
    // ****************************************
    // The enable sample may move only on a rising edge of the selected clock
    a_sample_on_rise: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        $changed(en_rise_q) |-> $past(rise)) else $error("Enable sampled off a rising edge");

    // The gate may move only in the first low cycle after a falling edge
    a_gate_after_fall: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        $changed(gate_q) |-> $past(fall)) else $error("Gate moved away from a falling edge");
    // Turning off needs a sampled low enable, mirroring the turn-on check
    a_stop_needs_rise: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        $fell(gate_on) |-> !$past(en_rise_q)) else $error("Disabled without rising edge sample");

    // While the clock is low the latch is open and must copy the sampled enable
    a_latch_open_low: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (!sel_clk && (gate_on != en_rise_q)) |=> (gate_on == $past(en_rise_q)))
        else $error("Latch did not follow while clock low");
    // A gated high pulse is either absent or exactly as long as the source phase
    a_full_width: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        fall |-> (gated_run_q == 8'h00 || gated_run_q == src_run_q)) else $error("Runt pulse on gated clock");

    // ****************************************
    // Routing and fanout checks
    // ****************************************
    // Each source must reach the outputs through the open gate one cycle later
    a_routes_diff: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (gate_on && pin_s.src_sel) |=> (O_FANOUT_OUTPUTS[0] == $past(diff_clk)))
        else $error("Differential source not routed");
    a_routes_single: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (gate_on && !pin_s.src_sel) |=> (O_FANOUT_OUTPUTS[0] == $past(pin_s.single_ended_in)))
        else $error("Single-ended source not routed");
    // All enables move together, so no output is driven while another floats
    a_enables_equal: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (O_FANOUT_OUTPUTS_OE_N == {NUM_OUT{O_FANOUT_OUTPUTS_OE_N[0]}})) else $error("Output enables differ");
    // The gate state must stay one of its two one-hot codes
    a_gate_one_hot: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        $onehot(gate_q)) else $error("Gate state not one-hot");
endmodule // cmgf_fanout

//--- sim/cmgf_clk_source.sv
// Upstream clock source model for the fanout bench
`timescale 1ns/10ps
module cmgf_clk_source (
    // Source clocks toward the fanout
    output logic o_diff_pos,
    output logic o_diff_neg,
    output logic o_single
);
    // Single-ended at 160 ns, differential at half rate so a wrong select shows
    initial begin
        o_single = 1'b0;
        #3;
        forever #80 o_single = ~o_single;
    end
    // Odd phase keeps the pair unrelated to the system clock
    initial begin
        o_diff_pos = 1'b0;
        #37;
        forever #160 o_diff_pos = ~o_diff_pos;
    end
    assign o_diff_neg = ~o_diff_pos; // True complement, never both high
endmodule // cmgf_clk_source

//--- sim/test_cmgf_fanout.sv
// Self-checking bench for the gated clock fanout
`timescale 1ns/10ps
module test_cmgf_fanout;
    logic I_SYS_CLK = 1'b0;
    logic I_RST = 1'b1;
    logic I_SRC_SEL = 1'b0;
    logic I_CLK_EN = 1'b0;
    logic I_OUT_EN = 1'b0;
    logic dp, dn, se, q_prev;
    logic [3:0] q, oe_n;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int rises, hi, min_hi;
    always #5 I_SYS_CLK = ~I_SYS_CLK;
    cmgf_clk_source src (.o_diff_pos(dp), .o_diff_neg(dn), .o_single(se));
    cmgf_fanout uut (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_DIFF_IN_POS(dp), .I_DIFF_IN_NEG(dn),
        .I_SINGLE_ENDED_IN(se), .I_SRC_SEL(I_SRC_SEL), .I_CLK_EN(I_CLK_EN), .I_OUT_EN(I_OUT_EN),
        .O_FANOUT_OUTPUTS(q), .O_FANOUT_OUTPUTS_OE_N(oe_n));
    // Pulse monitor on the falling edge, clear of the edge that launches the outputs;
    // the shortest high time exposes any runt pulse
    always @(negedge I_SYS_CLK) begin
        cycles = cycles + 1;
        if (q !== {4{q[0]}}) fail("outputs differ");
        if (q[0] === 1'b1) begin
            hi = hi + 1;
            if (q_prev !== 1'b1) rises = rises + 1;
        end else begin
            if (q_prev === 1'b1 && hi < min_hi) min_hi = hi;
            hi = 0;
        end
        q_prev = q[0];
        if (cycles > 5000) begin
            fail("timeout");
            close_out();
        end
    end
    task automatic fail(input string msg);
        mismatches++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    // Count pulses over 160 cycles; half-width pulses would be runts
    task automatic measure(input logic sel, input logic en, input int lo, input int up);
        I_SRC_SEL <= sel;
        I_CLK_EN <= en;
        repeat (40) @(posedge I_SYS_CLK);
        rises = 0;
        min_hi = 99;
        repeat (160) @(posedge I_SYS_CLK);
        tests_run++;
        if (rises < lo || rises > up) fail("pulse count");
        tests_run++;
        if (min_hi < 7) fail("short pulse");
    endtask
    task automatic t_release;
        I_CLK_EN <= 1'b1;
        repeat (6) @(posedge I_SYS_CLK);
        tests_run++;
        if (oe_n !== 4'hf) fail("not released");
        I_OUT_EN <= 1'b1;
        repeat (6) @(posedge I_SYS_CLK);
        tests_run++;
        if (oe_n !== 4'h0) fail("not driven");
    endtask
    // Enable flips at odd spacing against the link clock
    task automatic t_toggle;
        rises = 0;
        min_hi = 99;
        repeat (12) begin
            I_CLK_EN <= ~I_CLK_EN;
            repeat (23) @(posedge I_SYS_CLK);
        end
        tests_run++;
        if (min_hi < 7 || rises == 0) fail("runt on toggle");
    endtask
    // Enable latency: a full input period must pass before the first pulse, and
    // sync plus at most two periods bound it from above (16-cycle input period)
    task automatic t_latency;
        int n;
        n = 0;
        I_SRC_SEL <= 1'b0;
        I_CLK_EN <= 1'b0;
        repeat (40) @(posedge I_SYS_CLK);
        I_CLK_EN <= 1'b1;
        while (q[0] !== 1'b1 && n < 60) begin
            @(negedge I_SYS_CLK);
            n++;
        end
        @(posedge I_SYS_CLK);
        tests_run++;
        if (n < 18 || n > 38) fail("enable latency");
    endtask
    // Mid-run reset: outputs drop low and release at once, then drive resumes
    task automatic t_reset;
        I_RST <= 1'b1;
        repeat (2) @(posedge I_SYS_CLK);
        @(negedge I_SYS_CLK);
        tests_run++;
        if (q !== 4'h0 || oe_n !== 4'hf) fail("reset state");
        @(posedge I_SYS_CLK);
        I_RST <= 1'b0;
        repeat (6) @(posedge I_SYS_CLK);
        @(negedge I_SYS_CLK);
        tests_run++;
        if (oe_n !== 4'h0) fail("no drive after reset");
        @(posedge I_SYS_CLK);
    endtask
    task automatic close_out;
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge I_SYS_CLK);
        I_RST <= 1'b0;
        t_release();
        measure(1'b0, 1'b1, 9, 11);
        measure(1'b1, 1'b1, 4, 6);
        measure(1'b0, 1'b0, 0, 0);
        t_toggle();
        t_latency();
        t_reset();
        close_out();
    end
endmodule // test_cmgf_fanout
